// File: mnio_bitop.sv
`timescale 1ns/1ns
`default_nettype none
module mnio_bitop
   import mnio_pkg::*;
(
   input wire mnio_op_t op,
   input wire logic is_word,
   input wire logic [15:0] dst,
   input wire logic [7:0] count_low_reg,
   input wire logic [7:0] imm_idx,
   output logic [15:0] res,
   output logic cy,
   output logic ac,
   output logic v
);
   function automatic logic [3:0] bit_index(input logic [7:0] raw, input logic w);
      bit_index = w ? raw[MNIO_WORD_IDX_W-1:0] : {1'b0, raw[MNIO_BYTE_IDX_W-1:0]};
   endfunction
   logic [15:0] neg;
   logic [3:0] idx;
   always_comb begin
      neg = 16'h0 - dst;
      idx = 4'h0;
      res = dst;
      cy = 1'b0;
      ac = 1'b0;
      v = 1'b0;
      case (op)
         MNIO_OP_NEG: begin
            res = is_word ? neg : {8'h00, neg[7:0]};
            cy = is_word ? (dst != 16'h0) : (dst[7:0] != 8'h00);
            ac = (dst[3:0] != 4'h0);
            v = is_word ? (dst == 16'h8000) : (dst[7:0] == 8'h80);
         end
         MNIO_OP_NOT: begin
            res = is_word ? ~dst : {8'h00, ~dst[7:0]};
         end
         MNIO_OP_INVERT_ONE_BIT_OP_CL: begin
            idx = bit_index(count_low_reg, is_word);
            res = dst ^ (16'h0001 << idx);
         end
         MNIO_OP_INVERT_ONE_BIT_OP_IMM: begin
            idx = bit_index(imm_idx, is_word);
            res = dst ^ (16'h0001 << idx);
         end
         default: begin
            res = dst;
         end
      endcase
      if (!is_word) begin
         res[15:8] = 8'h00;
      end
   end
endmodule
`default_nettype wire

// File: mnio_mul.sv
`timescale 1ns/1ns
`default_nettype none
module mnio_mul
   import mnio_pkg::*;
(
   input wire mnio_op_t op,
   input wire logic [15:0] accum_word,
   input wire logic [15:0] src,
   input wire logic [15:0] imm,
   input wire logic imm_is_byte,
   output logic [15:0] lo,
   output logic [15:0] hi,
   output logic ovf
);
   logic signed [31:0] sp;
   logic [31:0] up;
   logic signed [15:0] mult;
   always_comb begin
      mult = imm_is_byte ? {{8{imm[7]}}, imm[7:0]} : imm;
      sp = 32'sh0;
      up = 32'h0;
      lo = 16'h0;
      hi = 16'h0;
      ovf = 1'b0;
      case (op)
         MNIO_OP_SMUL_B: begin
            sp = 32'(signed'({{8{accum_word[7]}}, accum_word[7:0]}) * signed'({{8{src[7]}}, src[7:0]}));
            lo = sp[15:0];
            ovf = (sp[15:8] != {8{sp[7]}});
         end
         MNIO_OP_SMUL_W: begin
            sp = 32'(signed'({{16{accum_word[15]}}, accum_word}) * signed'({{16{src[15]}}, src}));
            lo = sp[15:0];
            hi = sp[31:16];
            ovf = (sp[31:16] != {16{sp[15]}});
         end
         MNIO_OP_SMUL_IMM: begin
            sp = 32'(signed'({{16{src[15]}}, src}) * signed'({{16{mult[15]}}, mult}));
            lo = sp[15:0];
            ovf = (sp[31:16] != {16{sp[15]}});
         end
         MNIO_OP_UMUL_B: begin
            up = {16'h0, 8'h0, accum_word[7:0]} * {16'h0, 8'h0, src[7:0]};
            lo = up[15:0];
            ovf = (up[15:8] != 8'h00);
         end
         MNIO_OP_UMUL_W: begin
            up = {16'h0, accum_word} * {16'h0, src};
            lo = up[15:0];
            hi = up[31:16];
            ovf = (up[31:16] != 16'h0000);
         end
         default: begin
            lo = 16'h0;
         end
      endcase
   end
endmodule
`default_nettype wire

// File: mnio_pkg.sv
package mnio_pkg;
   typedef enum logic [3:0] {
      MNIO_OP_IDLE,
      MNIO_OP_SMUL_B,
      MNIO_OP_SMUL_W,
      MNIO_OP_SMUL_IMM,
      MNIO_OP_UMUL_B,
      MNIO_OP_UMUL_W,
      MNIO_OP_NEG,
      MNIO_OP_NOT,
      MNIO_OP_INVERT_ONE_BIT_OP_CL,
      MNIO_OP_INVERT_ONE_BIT_OP_IMM,
      MNIO_OP_CMC
   } mnio_op_t;
   localparam int MNIO_CLK_PERIOD_NS = 100;
   localparam int MNIO_IDLE_CYCLES = 3;
   localparam int MNIO_BYTE_IDX_W = 3;
   localparam int MNIO_WORD_IDX_W = 4;
   localparam logic [4:0] MNIO_FLAGS_RESET = 5'h00;
   localparam int MNIO_F_CY = 0;
   localparam int MNIO_F_V = 1;
   localparam int MNIO_F_P = 2;
   localparam int MNIO_F_S = 3;
   localparam int MNIO_F_Z = 4;
   localparam int MNIO_F_AC = 5;
   localparam int MNIO_SIZE_BIT = 0;
endpackage

// File: mnio_res_if.sv
`timescale 1ns/1ns
`default_nettype none
interface mnio_res_if;
   logic [15:0] acc;
   logic [15:0] ext;
   logic [15:0] dst;
   logic [5:0] flags;
   logic wr_acc;
   logic wr_ext;
   logic wr_dst;
   logic [5:0] flag_we;
   modport src(output acc, ext, dst, flags, wr_acc, wr_ext, wr_dst, flag_we);
   modport snk(input acc, ext, dst, flags, wr_acc, wr_ext, wr_dst, flag_we);
endinterface
`default_nettype wire

// File: mnio_top.sv
// What this block does
// - Signed byte multiply; flags on non-sign-extended high byte.
// - Signed word multiply into extension and accumulator.
// - Immediate signed multiply; flags when not 16-bit.
// - Unsigned byte multiply; flags when high byte nonzero.
// - Unsigned word multiply; flags when high half nonzero.
// - Invert all bits, flags untouched.
// - Invert one selected bit, flags untouched.
// - Count index uses low 3 or 4 bits.
// - Register immediate index from fourth byte, masked.
// - Memory immediate index from last byte, masked.
// - Carry complement changes only carry.
`timescale 1ns/1ns
`default_nettype none
module mnio_top
   import mnio_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic START,
   input wire mnio_op_t OP,
   input wire logic [7:0] OPCODE0,
   input wire logic [15:0] ACCUM_WORD_IN,
   input wire logic [15:0] SRC,
   input wire logic [15:0] DST_IN,
   input wire logic [15:0] IMM,
   input wire logic IMM_IS_BYTE,
   input wire logic [7:0] COUNT_LOW_REG,
   input wire logic [7:0] IMM_IDX_BYTE,
   input wire logic [5:0] FLAGS_IN,
   output logic BUSY,
   output logic DONE,
   output logic [15:0] ACCUM_WORD,
   output logic [15:0] EXTENSION_WORD_REG,
   output logic [15:0] DST_OUT,
   output logic WR_ACC,
   output logic WR_EXT,
   output logic WR_DST,
   output logic [5:0] FLAGS_OUT,
   output logic [5:0] FLAG_WE
);
   mnio_res_if res_bus();
   logic [15:0] mul_lo;
   logic [15:0] mul_hi;
   logic mul_ovf;
   logic [15:0] bit_res;
   logic bit_cy;
   logic bit_ac;
   logic bit_v;
   logic is_word;

   assign is_word = OPCODE0[MNIO_SIZE_BIT];

   mnio_mul u_mul (
      .op(OP),
      .accum_word(ACCUM_WORD_IN),
      .src(SRC),
      .imm(IMM),
      .imm_is_byte(IMM_IS_BYTE),
      .lo(mul_lo),
      .hi(mul_hi),
      .ovf(mul_ovf)
   );

   mnio_bitop u_bit (
      .op(OP),
      .is_word(is_word),
      .dst(DST_IN),
      .count_low_reg(COUNT_LOW_REG),
      .imm_idx(IMM_IDX_BYTE),
      .res(bit_res),
      .cy(bit_cy),
      .ac(bit_ac),
      .v(bit_v)
   );

   function automatic logic parity8(input logic [7:0] x);
      parity8 = ~^x;
   endfunction

   // Result select: one combinational view of what the current operation writes.
   always_comb begin
      logic [15:0] r;
      r = is_word ? bit_res : {8'h00, bit_res[7:0]};
      res_bus.acc = mul_lo;
      res_bus.ext = mul_hi;
      res_bus.dst = OP == MNIO_OP_SMUL_IMM ? mul_lo : bit_res;
      res_bus.flags = FLAGS_IN;
      res_bus.wr_acc = 1'b0;
      res_bus.wr_ext = 1'b0;
      res_bus.wr_dst = 1'b0;
      res_bus.flag_we = 6'h00;
      case (OP)
         MNIO_OP_SMUL_B, MNIO_OP_UMUL_B, MNIO_OP_SMUL_W, MNIO_OP_UMUL_W, MNIO_OP_SMUL_IMM: begin
            res_bus.wr_acc = (OP != MNIO_OP_SMUL_IMM);
            res_bus.wr_ext = (OP == MNIO_OP_SMUL_W) || (OP == MNIO_OP_UMUL_W);
            res_bus.wr_dst = (OP == MNIO_OP_SMUL_IMM);
            res_bus.flag_we = 6'h3F;
            // Undefined flags are cleared so runs repeat bit for bit.
            res_bus.flags = 6'h00;
            res_bus.flags[MNIO_F_CY] = mul_ovf;
            res_bus.flags[MNIO_F_V] = mul_ovf;
         end
         MNIO_OP_NEG: begin
            res_bus.wr_dst = 1'b1;
            res_bus.flag_we = 6'h3F;
            res_bus.flags[MNIO_F_CY] = bit_cy;
            res_bus.flags[MNIO_F_V] = bit_v;
            res_bus.flags[MNIO_F_AC] = bit_ac;
            res_bus.flags[MNIO_F_P] = parity8(r[7:0]);
            res_bus.flags[MNIO_F_S] = is_word ? r[15] : r[7];
            res_bus.flags[MNIO_F_Z] = (r == 16'h0000);
         end
         MNIO_OP_NOT, MNIO_OP_INVERT_ONE_BIT_OP_CL, MNIO_OP_INVERT_ONE_BIT_OP_IMM: begin
            res_bus.wr_dst = 1'b1;
         end
         MNIO_OP_CMC: begin
            res_bus.flag_we[MNIO_F_CY] = 1'b1;
            res_bus.flags[MNIO_F_CY] = ~FLAGS_IN[MNIO_F_CY];
         end
         default: begin
            res_bus.flag_we = 6'h00;
         end
      endcase
   end

   typedef enum logic [1:0] {MNIO_IDLE_ST, MNIO_WAIT_ST} mnio_state_t;
   mnio_state_t state;
   mnio_state_t next_state;
   logic [1:0] cnt;
   logic [1:0] next_cnt;
   logic next_busy;
   logic next_done;
   logic [15:0] next_acc;
   logic [15:0] next_ext;
   logic [15:0] next_dst;
   logic next_wr_acc;
   logic next_wr_ext;
   logic next_wr_dst;
   logic [5:0] next_flags;
   logic [5:0] next_flag_we;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_busy = 1'b0;
      next_done = 1'b0;
      next_acc = ACCUM_WORD;
      next_ext = EXTENSION_WORD_REG;
      next_dst = DST_OUT;
      next_flags = FLAGS_OUT;
      next_wr_acc = 1'b0;
      next_wr_ext = 1'b0;
      next_wr_dst = 1'b0;
      next_flag_we = 6'h00;
      case (state)
         MNIO_IDLE_ST: begin
            if (START && OP == MNIO_OP_IDLE) begin
               // Idle holds busy for all but the last of its cycles, drops it with done, and writes nothing.
               next_state = MNIO_WAIT_ST;
               next_cnt = 2'(MNIO_IDLE_CYCLES - 1);
               next_busy = 1'b1;
            end else if (START) begin
               next_done = 1'b1;
               next_acc = res_bus.acc;
               next_ext = res_bus.ext;
               next_dst = res_bus.dst;
               next_flags = res_bus.flags;
               next_wr_acc = res_bus.wr_acc;
               next_wr_ext = res_bus.wr_ext;
               next_wr_dst = res_bus.wr_dst;
               next_flag_we = res_bus.flag_we;
            end
         end
         MNIO_WAIT_ST: begin
            next_cnt = cnt - 2'h1;
            next_busy = (cnt != 2'h1);
            if (cnt == 2'h1) begin
               next_state = MNIO_IDLE_ST;
               next_done = 1'b1;
            end
         end
         default: begin
            next_state = MNIO_IDLE_ST;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state <= MNIO_IDLE_ST;
         cnt <= 2'h0;
         BUSY <= 1'b0;
         DONE <= 1'b0;
         ACCUM_WORD <= 16'h0000;
         EXTENSION_WORD_REG <= 16'h0000;
         DST_OUT <= 16'h0000;
         FLAGS_OUT <= 6'h00;
         WR_ACC <= 1'b0;
         WR_EXT <= 1'b0;
         WR_DST <= 1'b0;
         FLAG_WE <= 6'h00;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         BUSY <= next_busy;
         DONE <= next_done;
         ACCUM_WORD <= next_acc;
         EXTENSION_WORD_REG <= next_ext;
         DST_OUT <= next_dst;
         FLAGS_OUT <= next_flags;
         WR_ACC <= next_wr_acc;
         WR_EXT <= next_wr_ext;
         WR_DST <= next_wr_dst;
         FLAG_WE <= next_flag_we;
      end
   end

   a_idle_three_cycles: assert property (@(posedge CLK) disable iff (!RST_N)
      (START && OP == MNIO_OP_IDLE && state == MNIO_IDLE_ST) |=> BUSY[*2] ##1 DONE)
      else $error("idle did not take three cycles");
   a_idle_no_write: assert property (@(posedge CLK) disable iff (!RST_N)
      (state == MNIO_WAIT_ST) |-> !WR_ACC && !WR_EXT && !WR_DST && FLAG_WE == 6'h00)
      else $error("idle wrote state");
   a_umulw_flags: assert property (@(posedge CLK) disable iff (!RST_N)
      (START && state == MNIO_IDLE_ST && OP == MNIO_OP_UMUL_W) |=>
      FLAGS_OUT[MNIO_F_CY] == (EXTENSION_WORD_REG != 16'h0000) && WR_EXT)
      else $error("unsigned word flags wrong");
   a_smulb_flags: assert property (@(posedge CLK) disable iff (!RST_N)
      (START && state == MNIO_IDLE_ST && OP == MNIO_OP_SMUL_B) |=>
      FLAGS_OUT[MNIO_F_V] == (ACCUM_WORD[15:8] != {8{ACCUM_WORD[7]}}))
      else $error("signed byte flags wrong");
   a_smulw_flags: assert property (@(posedge CLK) disable iff (!RST_N)
      (START && state == MNIO_IDLE_ST && OP == MNIO_OP_SMUL_W) |=>
      FLAGS_OUT[MNIO_F_CY] == (EXTENSION_WORD_REG != {16{ACCUM_WORD[15]}}))
      else $error("signed word flags wrong");
   a_neg_carry: assert property (@(posedge CLK) disable iff (!RST_N)
      (START && state == MNIO_IDLE_ST && OP == MNIO_OP_NEG && is_word) |=>
      FLAGS_OUT[MNIO_F_CY] == ($past(DST_IN) != 16'h0000) && DST_OUT == 16'(16'h0 - $past(DST_IN)))
      else $error("negate result or carry wrong");
   a_not_flags: assert property (@(posedge CLK) disable iff (!RST_N)
      (START && state == MNIO_IDLE_ST && OP == MNIO_OP_NOT) |=>
      FLAG_WE == 6'h00 && WR_DST && (DST_OUT[7:0] == ~$past(DST_IN[7:0])))
      else $error("invert touched flags");
   a_invert_one_bit_op_cl_byte: assert property (@(posedge CLK) disable iff (!RST_N)
      (START && state == MNIO_IDLE_ST && OP == MNIO_OP_INVERT_ONE_BIT_OP_CL && !is_word) |=>
      (DST_OUT[7:0] ^ $past(DST_IN[7:0])) == 8'(8'h01 << $past(COUNT_LOW_REG[2:0])) && FLAG_WE == 6'h00)
      else $error("bit invert index wrong");
   a_cmc_only: assert property (@(posedge CLK) disable iff (!RST_N)
      (START && state == MNIO_IDLE_ST && OP == MNIO_OP_CMC) |=>
      FLAG_WE == 6'h01 && FLAGS_OUT[MNIO_F_CY] != $past(FLAGS_IN[MNIO_F_CY]))
      else $error("carry complement wrong");
   c_idle: cover property (@(posedge CLK) START && OP == MNIO_OP_IDLE ##3 DONE);
   c_smul_ovf: cover property (@(posedge CLK) START && OP == MNIO_OP_SMUL_IMM && mul_ovf);
   c_neg_zero: cover property (@(posedge CLK) START && OP == MNIO_OP_NEG && DST_IN == 16'h0000);
endmodule
`default_nettype wire

// File: mnio_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module mnio_top_test
   import mnio_pkg::*;
();
   logic clk, rst_n, start, imm_is_byte, busy, done, wr_acc, wr_ext, wr_dst;
   mnio_op_t op;
   logic [7:0] opcode0, count_low_reg, imm_idx_byte;
   logic [15:0] acc_in, src, dst_in, imm, accum_word, ext_word, dst_out;
   logic [5:0] flags_in, flags_out, flag_we;
   int err_count, comparisons, cycles, base_n, n, nb;

   mnio_top i_dut (.CLK(clk), .RST_N(rst_n), .START(start), .OP(op), .OPCODE0(opcode0),
      .ACCUM_WORD_IN(acc_in), .SRC(src), .DST_IN(dst_in), .IMM(imm), .IMM_IS_BYTE(imm_is_byte),
      .COUNT_LOW_REG(count_low_reg), .IMM_IDX_BYTE(imm_idx_byte), .FLAGS_IN(flags_in),
      .BUSY(busy), .DONE(done), .ACCUM_WORD(accum_word), .EXTENSION_WORD_REG(ext_word),
      .DST_OUT(dst_out), .WR_ACC(wr_acc), .WR_EXT(wr_ext), .WR_DST(wr_dst),
      .FLAGS_OUT(flags_out), .FLAG_WE(flag_we));

   initial clk = 1'b0;
   always #(MNIO_CLK_PERIOD_NS / 2) clk = ~clk;

   // The sequence needs under a hundred cycles, so this ceiling only trips on a hang.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count++;
         $display("Error at %0t: run timed out", $time);
         print_verdict();
      end
   end

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: %s %h, expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk6(input logic [5:0] got, input logic [5:0] exp, input string what);
      chk16({10'h000, got}, {10'h000, exp}, what);
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      chk16({15'h0000, got}, {15'h0000, exp}, what);
   endtask

   // Issues one request and waits, bounded, for the completion strobe.
   task automatic fire();
      // One spare edge keeps start from being lowered and raised in one time step.
      @(negedge clk);
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      n = 1;
      while (done !== 1'b1 && n < 12) begin
         @(negedge clk);
         n++;
      end
      chk1(done, 1'b1, "done");
      base_n = n;
   endtask

   task automatic do_mul(input mnio_op_t o, input logic [15:0] a, input logic [15:0] b, input logic ib);
      logic [31:0] x, y, p;
      logic ov, word;
      op = o;
      acc_in = a;
      src = (o == MNIO_OP_SMUL_IMM) ? a : b;
      imm = b;
      imm_is_byte = ib;
      x = {{16{a[15]}}, a};
      y = {{16{b[15]}}, b};
      if (o == MNIO_OP_SMUL_B) begin
         x = {{24{a[7]}}, a[7:0]};
         y = {{24{b[7]}}, b[7:0]};
      end else if (o == MNIO_OP_UMUL_B) begin
         x = {24'h000000, a[7:0]};
         y = {24'h000000, b[7:0]};
      end else if (o == MNIO_OP_UMUL_W) begin
         x = {16'h0000, a};
         y = {16'h0000, b};
      end else if (o == MNIO_OP_SMUL_IMM && ib) begin
         y = {{24{b[7]}}, b[7:0]};
      end
      p = x * y;
      case (o)
         MNIO_OP_SMUL_B: ov = p[15:8] != {8{p[7]}};
         MNIO_OP_UMUL_B: ov = p[15:8] != 8'h00;
         MNIO_OP_UMUL_W: ov = p[31:16] != 16'h0000;
         default: ov = p[31:16] != {16{p[15]}};
      endcase
      word = (o == MNIO_OP_SMUL_W) || (o == MNIO_OP_UMUL_W);
      fire();
      chk6(flags_out, {4'h0, ov, ov}, "mul flags");
      chk6(flag_we, 6'h3F, "mul flag enables");
      if (o == MNIO_OP_SMUL_IMM) begin
         chk16(dst_out, p[15:0], "imm product");
         chk1(wr_dst, 1'b1, "dst write");
         chk1(wr_acc, 1'b0, "no acc write");
      end else begin
         chk16(accum_word, p[15:0], "low product");
         chk1(wr_acc, 1'b1, "acc write");
         chk1(wr_ext, word, "ext write");
         if (word) chk16(ext_word, p[31:16], "high product");
      end
   endtask

   task automatic t_mul();
      do_mul(MNIO_OP_SMUL_B, 16'h12FF, 16'h3402, 1'b0);
      do_mul(MNIO_OP_SMUL_B, 16'h0080, 16'h0080, 1'b0);
      do_mul(MNIO_OP_SMUL_W, 16'hFFFF, 16'h0002, 1'b0);
      do_mul(MNIO_OP_SMUL_W, 16'h4000, 16'h0002, 1'b0);
      do_mul(MNIO_OP_SMUL_IMM, 16'h0100, 16'h00FF, 1'b1);
      do_mul(MNIO_OP_SMUL_IMM, 16'h0100, 16'h0080, 1'b0);
      do_mul(MNIO_OP_UMUL_B, 16'hAA0F, 16'h0010, 1'b0);
      do_mul(MNIO_OP_UMUL_B, 16'h00FF, 16'h00FF, 1'b0);
      do_mul(MNIO_OP_UMUL_W, 16'hFFFF, 16'h0001, 1'b0);
      do_mul(MNIO_OP_UMUL_W, 16'h0100, 16'h0100, 1'b0);
      $display("Test multiply done");
   endtask

   task automatic do_neg(input logic w, input logic [15:0] d);
      logic [15:0] r;
      logic [5:0] f;
      op = MNIO_OP_NEG;
      opcode0 = 8'(w) << MNIO_SIZE_BIT;
      dst_in = d;
      r = w ? 16'h0000 - d : {8'h00, 8'h00 - d[7:0]};
      f = {d[3:0] != 4'h0, r == 16'h0000, w ? r[15] : r[7], 1'b0,
           w ? d == 16'h8000 : d[7:0] == 8'h80, w ? d != 16'h0000 : d[7:0] != 8'h00};
      fire();
      chk16(dst_out, r, "negated");
      chk6(flags_out & 6'h3B, f, "neg flags");
      chk6(flag_we, 6'h3F, "neg flag enables");
   endtask

   task automatic t_neg();
      do_neg(1'b0, 16'hAB00);
      do_neg(1'b0, 16'h0080);
      do_neg(1'b1, 16'h8000);
      do_neg(1'b1, 16'h0010);
      $display("Test negate done");
   endtask

   task automatic do_inv(input mnio_op_t o, input logic w, input logic [15:0] d, input logic [7:0] idx);
      logic [15:0] r;
      op = o;
      opcode0 = 8'(w) << MNIO_SIZE_BIT;
      dst_in = d;
      count_low_reg = (o == MNIO_OP_INVERT_ONE_BIT_OP_IMM) ? ~idx : idx;
      imm_idx_byte = (o == MNIO_OP_INVERT_ONE_BIT_OP_CL) ? ~idx : idx;
      r = (o == MNIO_OP_NOT) ? ~d : d ^ (16'h0001 << (w ? idx[3:0] : {1'b0, idx[2:0]}));
      if (!w) r = {8'h00, r[7:0]};
      fire();
      chk16(dst_out, r, "inverted");
      chk1(wr_dst, 1'b1, "dst write");
      chk6(flag_we, 6'h00, "inv flag enables");
   endtask

   task automatic t_inv();
      flags_in = 6'h3F;
      do_inv(MNIO_OP_NOT, 1'b0, 16'hA55A, 8'h00);
      do_inv(MNIO_OP_NOT, 1'b1, 16'h0FF0, 8'h00);
      do_inv(MNIO_OP_INVERT_ONE_BIT_OP_CL, 1'b0, 16'h1200, 8'hFF);
      do_inv(MNIO_OP_INVERT_ONE_BIT_OP_CL, 1'b1, 16'hFFFF, 8'h13);
      do_inv(MNIO_OP_INVERT_ONE_BIT_OP_IMM, 1'b0, 16'h0000, 8'hFE);
      do_inv(MNIO_OP_INVERT_ONE_BIT_OP_IMM, 1'b1, 16'h0000, 8'h4A);
      $display("Test inversion done");
   endtask

   task automatic t_cmc();
      logic [5:0] fi[2] = '{6'h2A, 6'h15};
      foreach (fi[i]) begin
         op = MNIO_OP_CMC;
         flags_in = fi[i];
         fire();
         chk1(flags_out[MNIO_F_CY], ~fi[i][0], "carry");
         chk6(flag_we, 6'h01, "carry enable");
      end
      $display("Test carry complement done");
   endtask

   // New requests are offered while the idle op counts; they must be dropped.
   task automatic t_idle();
      @(negedge clk);
      op = MNIO_OP_IDLE;
      start = 1'b1;
      @(negedge clk);
      n = 1;
      nb = 0;
      while (done !== 1'b1 && n < 12) begin
         start = (busy === 1'b1);
         op = MNIO_OP_NOT;
         if (busy === 1'b1) nb++;
         @(negedge clk);
         n++;
      end
      start = 1'b0;
      chk16(16'(n), 16'(MNIO_IDLE_CYCLES), "idle latency");
      chk16(16'(nb), 16'(MNIO_IDLE_CYCLES - 1), "busy cycles");
      chk1(busy, 1'b0, "busy at done");
      chk1(wr_acc | wr_ext | wr_dst, 1'b0, "idle writes");
      chk6(flag_we, 6'h00, "idle flag enables");
      repeat (4) begin
         @(negedge clk);
         chk1(done, 1'b0, "refused request");
      end
      $display("Test idle done");
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      err_count = 0;
      comparisons = 0;
      cycles = 0;
      base_n = 2;
      rst_n = 1'b0;
      start = 1'b0;
      op = MNIO_OP_IDLE;
      opcode0 = 8'h00;
      imm_is_byte = 1'b0;
      {acc_in, src, dst_in, imm} = 64'h0;
      {count_low_reg, imm_idx_byte} = 16'h0000;
      flags_in = 6'h00;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      chk1(done, 1'b0, "done after reset");
      chk16(accum_word, 16'h0000, "accum after reset");
      chk6(flag_we, 6'h00, "enables after reset");
      t_inv();
      t_neg();
      t_mul();
      t_cmc();
      t_idle();
      print_verdict();
   end
endmodule
`default_nettype wire
